// ---- watchdog_reset_status_options.v ----
// Function
// [R01] set active cause flags, clear others
// [R02] debug forced reset leaves flags clear
// [R03] bad service write causes watchdog reset
// [R04] 0x55 then 0xaa clears watchdog counter
// [R05] power-on sets bits 7 and 1
// [R06] reset pin low sets bit 6
// [R07] timeout resets, sets bit 5, if enabled
// [R08] bad opcode, stop, background set bit 4
// [R09] bad address access sets bit 3
// [R10] clock loss sets bit 2
// [R11] enabled low voltage trip sets bit 1
// [R12] force register: debug writes only, reads zero
// [R13] debug force bit one gives reset
// [R14] options accept first write only
// [R15] stop with stop disallowed is bad opcode
// [R16] bit 4 places second serial pins
// [R17] bit 3 places two-wire pins
// [R18] timeout code zero disables watchdog
// [R19] low-power clock periods 2^5, 2^8, 2^10
// [R20] bus periods 2^13, 2^16, 2^18, window
// [R21] software services only in final quarter
// [R22] early write in window mode resets
// [R23] clock select: low-power or bus clock
// [R24] any reset restarts counter from zero
`include "wdog_map.vh"
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_status_options
#(
    parameter LPO_DIVIDE = `LPO_DIVIDE
)
(
    input  wire       clock_in,           // bus clock, 10 MHz
    input  wire       rst_in,             // power-on reset, active high
    input  wire       enable_in,          // clock enable
    input  wire       reg_write_in,       // user register write strobe
    input  wire       reg_read_in,        // user register read strobe
    input  wire       debug_write_in,     // background debug write strobe
    input  wire [7:0] reg_address_in,     // register address
    input  wire [7:0] reg_wdata_in,       // write data
    input  wire       reset_pin_n_in,     // external reset pin, active low
    input  wire       bad_opcode_in,      // illegal opcode executed
    input  wire       stop_exec_in,       // stop instruction executed
    input  wire       background_exec_in, // background instruction executed
    input  wire       background_mode_allow_in, // background mode allowed
    input  wire       bad_address_in,     // unimplemented address access
    input  wire       clock_loss_in,      // external clock lost
    input  wire       low_voltage_in,     // supply below trip level
    input  wire       low_voltage_reset_enable_in, // low voltage reset on
    output reg  [7:0] reg_rdata_out,      // read data
    output reg        system_reset_out,   // reset to the rest of the chip
    output reg        stop_enter_out,     // stop mode may be entered
    output reg        serial_two_on_e_out, // serial pins on port e pair
    output reg        two_wire_on_e_out   // two-wire pins on port e pair
);

    // synchronised pin and monitor inputs
    reg  [1:0] pin_sync;
    reg  [1:0] loss_sync;
    reg  [1:0] volt_sync;
    wire       pin_low  = ~pin_sync[1];
    wire       clk_lost = loss_sync[1];
    wire       volt_low = volt_sync[1];

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_sync  <= 2'h3;
            loss_sync <= 2'h0;
            volt_sync <= 2'h0;
        end
        else if (enable_in)
        begin
            pin_sync  <= {pin_sync[0], reset_pin_n_in};
            loss_sync <= {loss_sync[0], clock_loss_in};
            volt_sync <= {volt_sync[0], low_voltage_in};
        end
    end

    reg  [7:0] options;
    reg        options_written;
    reg  [7:0] options_two;
    reg        options_two_written;
    reg  [18:0] wd_count;
    reg  [16:0] lpo_div;
    reg        service_armed;
    reg  [3:0] pulse_count;
    wire [7:0] cause;

    wire [1:0] timeout_sel = options[`SO_TIMEOUT_HI:`SO_TIMEOUT_LO];
    wire       bus_clock   = options_two[`SO2_CLOCK_SEL];
    wire       window_mode = options_two[`SO2_WINDOW];
    wire       wd_enabled  = (timeout_sel != 2'h0); // see [R18]

    // overflow exponent from timeout code and clock select
    function [4:0] overflow_exp;
        input [1:0] sel;
        input       bus;
        begin
            case ({bus, sel})
                3'h1:    overflow_exp = `EXP_LPO_1; // see [R19]
                3'h2:    overflow_exp = `EXP_LPO_2;
                3'h3:    overflow_exp = `EXP_LPO_3;
                3'h5:    overflow_exp = `EXP_BUS_1; // see [R20]
                3'h6:    overflow_exp = `EXP_BUS_2;
                3'h7:    overflow_exp = `EXP_BUS_3;
                default: overflow_exp = 5'h1f;
            endcase
        end
    endfunction

    wire [4:0]  exp_now   = overflow_exp(timeout_sel, bus_clock);
    wire [18:0] limit     = (19'h1 << exp_now) - 19'h1;
    wire [18:0] window_at = limit - (limit >> 2); // 75% of period

    // watchdog tick: every bus cycle or every low-power period
    wire lpo_tick = (lpo_div == LPO_DIVIDE[16:0] - 17'h1);
    wire wd_tick  = bus_clock ? 1'b1 : lpo_tick; // see [R23]

    wire user_wr     = enable_in && reg_write_in;
    wire cause_wr    = user_wr && (reg_address_in == `ADDR_RESET_CAUSE);
    wire is_first    = (reg_wdata_in == `SERVICE_FIRST);
    wire is_second   = (reg_wdata_in == `SERVICE_SECOND);
    wire early_write = window_mode && (wd_count < window_at);

    // service and watchdog fault decode
    wire bad_value   = cause_wr && !is_first && !is_second; // see [R03]
    wire early_fault = cause_wr && early_write;             // see [R22]
    wire service_ok  = cause_wr && is_second && service_armed
                       && !early_write;                     // see [R04]
    wire timeout     = wd_tick && (wd_count >= limit);
    wire wd_fault    = wd_enabled
                       && (bad_value || early_fault || timeout); // see [R07]

    // opcode faults, stop and background count as bad when disallowed
    wire stop_bad = stop_exec_in && !options[`SO_STOP_ALLOW]; // see [R15]
    wire op_fault = bad_opcode_in || stop_bad
                    || (background_exec_in && !background_mode_allow_in);
    wire lv_fault = low_voltage_reset_enable_in && volt_low;  // see [R11]

    // debug force, only via background debug path
    wire force_reset = enable_in && debug_write_in
                       && (reg_address_in == `ADDR_DEBUG_FORCE_RESET)
                       && reg_wdata_in[`DF_FORCE_BIT];          // see [R13]

    wire any_source = pin_low || wd_fault || op_fault || bad_address_in
                      || clk_lost || lv_fault;
    wire reset_now  = enable_in && !system_reset_out
                      && (any_source || force_reset);

    // cause captured on reset entry; forced reset records nothing
    reg [7:0] next_cause;
    always @*
    begin
        next_cause = 8'h00;
        if (!force_reset)                                       // see [R02]
        begin
            next_cause[`RC_PIN]         = pin_low;               // see [R06]
            next_cause[`RC_WATCHDOG]    = wd_fault;
            next_cause[`RC_BAD_OPCODE]  = op_fault;              // see [R08]
            next_cause[`RC_BAD_ADDRESS] = bad_address_in;        // see [R09]
            next_cause[`RC_CLOCK_LOSS]  = clk_lost;              // see [R10]
            next_cause[`RC_LOW_VOLTAGE] = lv_fault;
        end
    end

    // power-on value 0x82 comes from the store reset, see [R05]
    reset_cause_store u_cause
    (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .enable_in  (enable_in),
        .capture_in (reset_now), // see [R01]
        .cause_in   (next_cause),
        .cause_out  (cause)
    );

    // reset pulse, held while a pin or monitor source persists
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            system_reset_out <= 1'b1;
            pulse_count      <= `RESET_PULSE_CYCLES;
        end
        else if (enable_in)
        begin
            if (reset_now)
            begin
                system_reset_out <= 1'b1;
                pulse_count      <= `RESET_PULSE_CYCLES;
            end
            else if (system_reset_out)
            begin
                if (pulse_count != 4'h0)
                    pulse_count <= pulse_count - 4'h1;
                else if (!pin_low && !clk_lost && !lv_fault)
                    system_reset_out <= 1'b0;
            end
        end
    end

    wire in_reset = system_reset_out;

    // watchdog counter and service sequence
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wd_count      <= 19'h0;
            lpo_div       <= 17'h0;
            service_armed <= 1'b0;
        end
        else if (enable_in)
        begin
            if (in_reset || reset_now)
            begin
                wd_count      <= 19'h0;                          // see [R24]
                lpo_div       <= 17'h0;
                service_armed <= 1'b0;
            end
            else
            begin
                lpo_div <= lpo_tick ? 17'h0 : lpo_div + 17'h1;
                if (service_ok)
                    wd_count <= 19'h0;                           // see [R04]
                else if (wd_enabled && wd_tick)
                    wd_count <= wd_count + 19'h1;
                if (cause_wr)
                    service_armed <= is_first;
            end
        end
    end

    // write-once option registers, survive only until next reset
    wire opt_wr  = user_wr && (reg_address_in == `ADDR_SYSTEM_OPTIONS);
    wire opt2_wr = user_wr && (reg_address_in == `ADDR_SYSTEM_OPTIONS_TWO);

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            options             <= `SO_RESET_VALUE;
            options_written     <= 1'b0;
            options_two         <= `SO2_RESET_VALUE;
            options_two_written <= 1'b0;
        end
        else if (enable_in)
        begin
            if (in_reset)
            begin
                options             <= `SO_RESET_VALUE;
                options_written     <= 1'b0;
                options_two         <= `SO2_RESET_VALUE;
                options_two_written <= 1'b0;
            end
            else
            begin
                if (opt_wr && !options_written)                  // see [R14]
                begin
                    options         <= reg_wdata_in;
                    options_written <= 1'b1;
                end
                if (opt2_wr && !options_two_written)
                begin
                    options_two         <= reg_wdata_in & 8'hc0;
                    options_two_written <= 1'b1;
                end
            end
        end
    end

    // read data and pin placement outputs
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out       <= 8'h00;
            stop_enter_out      <= 1'b0;
            serial_two_on_e_out <= 1'b0;
            two_wire_on_e_out   <= 1'b0;
        end
        else if (enable_in)
        begin
            stop_enter_out      <= stop_exec_in && options[`SO_STOP_ALLOW];
            serial_two_on_e_out <= options[`SO_SERIAL_PIN];     // see [R16]
            two_wire_on_e_out   <= options[`SO_TWO_WIRE];       // see [R17]
            if (reg_read_in)
            begin
                case (reg_address_in)
                    `ADDR_RESET_CAUSE:        reg_rdata_out <= cause;
                    `ADDR_DEBUG_FORCE_RESET:
                        reg_rdata_out <= 8'h00;             // see [R12]
                    `ADDR_SYSTEM_OPTIONS:     reg_rdata_out <= options;
                    `ADDR_SYSTEM_OPTIONS_TWO: reg_rdata_out <= options_two;
                    default:                  reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- wdog_map.vh ----
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH

// register addresses on the internal register port
`define ADDR_RESET_CAUSE        8'h00
`define ADDR_DEBUG_FORCE_RESET  8'h01
`define ADDR_SYSTEM_OPTIONS     8'h02
`define ADDR_SYSTEM_OPTIONS_TWO 8'h03

// reset_cause fields
`define RC_POWER_ON    7
`define RC_PIN         6
`define RC_WATCHDOG    5
`define RC_BAD_OPCODE  4
`define RC_BAD_ADDRESS 3
`define RC_CLOCK_LOSS  2
`define RC_LOW_VOLTAGE 1
`define RC_RESET_VALUE 8'h82

// system_options_first fields
`define SO_TIMEOUT_HI  7
`define SO_TIMEOUT_LO  6
`define SO_STOP_ALLOW  5
`define SO_SERIAL_PIN  4
`define SO_TWO_WIRE    3
`define SO_RESET_VALUE 8'hc0

// second options fields
`define SO2_CLOCK_SEL  7
`define SO2_WINDOW     6
`define SO2_RESET_VALUE 8'h00

// service sequence values
`define SERVICE_FIRST  8'h55
`define SERVICE_SECOND 8'haa

// debug force bit
`define DF_FORCE_BIT   0

// low-power clock period in ns, and bus clock period in ns
`define LOW_POWER_CLOCK_PERIOD_NS 1000000
`define BUS_CLOCK_PERIOD_NS       100
`define LPO_DIVIDE (`LOW_POWER_CLOCK_PERIOD_NS / `BUS_CLOCK_PERIOD_NS)

// overflow exponents per timeout code
`define EXP_LPO_1 5'h05
`define EXP_LPO_2 5'h08
`define EXP_LPO_3 5'h0a
`define EXP_BUS_1 5'h0d
`define EXP_BUS_2 5'h10
`define EXP_BUS_3 5'h12

// width of the reset pulse issued to the system
`define RESET_PULSE_CYCLES 4'h4

`endif

// ---- reset_cause_store.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.vh"

// holds the latched reset cause; register output, write on capture only
module reset_cause_store
(
    input  wire       clock_in,   // system clock
    input  wire       rst_in,     // async reset, active high
    input  wire       enable_in,  // clock enable
    input  wire       capture_in, // latch new cause
    input  wire [7:0] cause_in,   // new cause value
    output reg  [7:0] cause_out   // stored cause
);

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cause_out <= `RC_RESET_VALUE;
        end
        else if (enable_in && capture_in)
        begin
            cause_out <= cause_in;
        end
    end

endmodule

`default_nettype wire

// ---- core_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_host
(
    input  wire logic       clock_in,  // bus clock
    input  wire logic [7:0] rdata_in,  // read data
    output logic            wr_out,    // user write
    output logic            rd_out,    // read
    output logic            dw_out,    // debug write
    output logic      [7:0] addr_out,  // address
    output logic      [7:0] data_out,  // write data
    output logic      [3:0] ev_out     // opcode, address, stop, background
);
    initial
    begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        dw_out = 1'b0;
        addr_out = 8'h00;
        data_out = 8'h00;
        ev_out = 4'h0;
    end
    // released address and data lines show the inverse of the last value; write strobes drop to zero
    task wr(input logic dbg, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_out <= !dbg;
        dw_out <= dbg;
        addr_out <= a;
        data_out <= d;
        @(posedge clock_in);
        wr_out <= 1'b0;
        dw_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clock_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clock_in);
        #1;
        d = rdata_in;
    endtask
    task service;
        wr(1'b0, 8'h00, 8'h55);
        wr(1'b0, 8'h00, 8'haa);
    endtask
    task pulse(input int k);
        @(posedge clock_in);
        ev_out <= 4'h1 << k;
        @(posedge clock_in);
        ev_out <= 4'h0;
    endtask
endmodule
`default_nettype wire

// ---- wdog_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdog_monitor
(
    input wire logic       clock_in,       // clock
    input wire logic       rst_in,         // reset
    input wire logic       enable_in,      // enable
    input wire logic       reg_read_in,    // read
    input wire logic       debug_write_in, // debug write
    input wire logic [7:0] reg_address_in, // address
    input wire logic [7:0] reg_wdata_in,   // data
    input wire logic       reset_pin_n_in, // pin
    input wire logic       bad_opcode_in,  // event
    input wire logic       bad_address_in, // event
    input wire logic       clock_loss_in,  // level
    input wire logic       low_voltage_in, // level
    input wire logic       low_voltage_reset_enable_in, // level
    input wire logic [7:0] reg_rdata_out,  // read data
    input wire logic       system_reset_out // reset
);
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    property p_force;
        enable_in && debug_write_in && reg_address_in == 8'h01
            && reg_wdata_in[0] |=> system_reset_out;
    endproperty
    a_force: assert property (p_force)
        else $error("forced reset missing");
    property p_opcode;
        enable_in && bad_opcode_in |=> system_reset_out;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("opcode reset missing");
    property p_address;
        enable_in && bad_address_in |=> system_reset_out;
    endproperty
    a_address: assert property (p_address)
        else $error("address reset missing");
    property p_read_zero;
        enable_in && reg_read_in && reg_address_in == 8'h01
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("force register read not zero");
    property p_hold;
        $rose(system_reset_out) |=> system_reset_out [*4];
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset pulse too short");
    property p_pin;
        (enable_in && !reset_pin_n_in) [*4] |-> system_reset_out;
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin reset missing");
    property p_loss;
        (enable_in && clock_loss_in) [*4] |-> system_reset_out;
    endproperty
    a_loss: assert property (p_loss)
        else $error("clock loss reset missing");
    property p_low;
        (enable_in && low_voltage_in && low_voltage_reset_enable_in) [*4]
            |-> system_reset_out;
    endproperty
    a_low: assert property (p_low)
        else $error("low voltage reset missing");
endmodule
bind watchdog_reset_status_options wdog_monitor u_mon
(
    .clock_in, .rst_in, .enable_in, .reg_read_in, .debug_write_in,
    .reg_address_in, .reg_wdata_in, .reset_pin_n_in, .bad_opcode_in,
    .bad_address_in, .clock_loss_in, .low_voltage_in,
    .low_voltage_reset_enable_in, .reg_rdata_out, .system_reset_out
);
`default_nettype wire

// ---- tb_watchdog_reset_status_options.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_status_options;
    logic       clock_in;
    logic       rst_in;
    logic       enable_in;
    logic       stop_enter_out;
    logic       reg_write_in;
    logic       reg_read_in;
    logic       debug_write_in;
    logic [7:0] reg_address_in;
    logic [7:0] reg_wdata_in;
    logic [3:0] ev;
    logic       reset_pin_n_in;
    logic       background_mode_allow_in;
    logic       clock_loss_in;
    logic       low_voltage_in;
    logic       low_voltage_reset_enable_in;
    logic [7:0] reg_rdata_out;
    logic       system_reset_out;
    logic       serial_two_on_e_out;
    logic       two_wire_on_e_out;
    logic [7:0] d;
    logic       hit;
    int         n_fail;
    int         tests_run;
    core_host u_host (.clock_in(clock_in), .rdata_in(reg_rdata_out),
        .wr_out(reg_write_in), .rd_out(reg_read_in), .dw_out(debug_write_in),
        .addr_out(reg_address_in), .data_out(reg_wdata_in), .ev_out(ev));
    watchdog_reset_status_options #(.LPO_DIVIDE(4)) u_dut (.clock_in,
        .rst_in, .enable_in, .reg_write_in, .reg_read_in,
        .debug_write_in, .reg_address_in, .reg_wdata_in, .reset_pin_n_in,
        .bad_opcode_in(ev[0]), .stop_exec_in(ev[2]),
        .background_exec_in(ev[3]), .background_mode_allow_in,
        .bad_address_in(ev[1]), .clock_loss_in, .low_voltage_in,
        .low_voltage_reset_enable_in, .reg_rdata_out, .system_reset_out,
        .stop_enter_out, .serial_two_on_e_out, .two_wire_on_e_out);
    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wait_for(input logic v, input int n);
        for (int i = 0; i < n && system_reset_out !== v; i++)
            @(posedge clock_in);
        #1;
        check({7'h0, system_reset_out}, {7'h0, v});
        if (system_reset_out !== v)
            stop_test;
    endtask
    task seen_reset(input logic [7:0] exp);
        wait_for(1'b1, 300);
        wait_for(1'b0, 60);
        u_host.rd(8'h00, d);
        check(d, exp);
    endtask
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst_in = 1'b1;
        enable_in = 1'b1;
        reset_pin_n_in = 1'b1;
        clock_loss_in = 1'b0;
        low_voltage_in = 1'b0;
        low_voltage_reset_enable_in = 1'b1;
        background_mode_allow_in = 1'b0;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        wait_for(1'b0, 60);
        u_host.rd(8'h00, d);
        check(d, 8'h82);
        u_host.rd(8'h02, d);
        check(d, 8'hc0);
        u_host.wr(1'b0, 8'h01, 8'h01);
        repeat (10) @(posedge clock_in);
        check({7'h0, system_reset_out}, 8'h00);
        u_host.wr(1'b1, 8'h01, 8'h01);
        seen_reset(8'h00);
        u_host.wr(1'b0, 8'h02, 8'h78);
        repeat (6)
        begin
            u_host.service();
            repeat (60) @(posedge clock_in);
            check({7'h0, system_reset_out}, 8'h00);
        end
        u_host.rd(8'h01, d);
        check(d, 8'h00);
        u_host.wr(1'b0, 8'h02, 8'h00);
        u_host.rd(8'h02, d);
        check(d, 8'h78);
        check({7'h0, serial_two_on_e_out}, 8'h01);
        check({7'h0, two_wire_on_e_out}, 8'h01);
        u_host.rd(8'h00, d);
        check(d, 8'h00);
        u_host.pulse(2);
        #1 check({7'h0, stop_enter_out}, 8'h01);
        @(posedge clock_in);
        background_mode_allow_in <= 1'b1;
        u_host.pulse(3);
        repeat (2) @(posedge clock_in);
        background_mode_allow_in <= 1'b0;
        #1 check({7'h0, system_reset_out}, 8'h00);
        seen_reset(8'h20);
        u_host.wr(1'b0, 8'h00, 8'h12);
        seen_reset(8'h20);
        for (int k = 0; k < 4; k++)
        begin
            u_host.pulse(k);
            seen_reset(k == 1 ? 8'h08 : 8'h10);
        end
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clock_in);
            reset_pin_n_in <= (k != 0);
            clock_loss_in <= (k == 1);
            low_voltage_in <= (k == 2);
            wait_for(1'b1, 20);
            repeat (5) @(posedge clock_in);
            reset_pin_n_in <= 1'b1;
            clock_loss_in <= 1'b0;
            low_voltage_in <= 1'b0;
            seen_reset(k == 0 ? 8'h40
                       : (k == 1 ? 8'h04 : 8'h02));
        end
        u_host.wr(1'b0, 8'h02, 8'h40);
        u_host.wr(1'b0, 8'h03, 8'hc0);
        u_host.wr(1'b0, 8'h00, 8'h55);
        seen_reset(8'h20);
        u_host.wr(1'b0, 8'h02, 8'h40);
        u_host.wr(1'b0, 8'h03, 8'hc0);
        repeat (6200) @(posedge clock_in);
        u_host.service();
        u_host.rd(8'h03, d);
        check(d, 8'hc0);
        repeat (8000) @(posedge clock_in);
        check({7'h0, system_reset_out}, 8'h00);
        seen_reset(8'h20);
        u_host.wr(1'b0, 8'h02, 8'h00);
        low_voltage_reset_enable_in <= 1'b0;
        low_voltage_in <= 1'b1;
        enable_in <= 1'b0;
        u_host.pulse(0);
        enable_in <= 1'b1;
        hit = 1'b0;
        repeat (5000)
        begin
            @(posedge clock_in);
            hit = hit | system_reset_out;
        end
        check({7'h0, hit}, 8'h00);
        stop_test;
    end
endmodule
`default_nettype wire
